/* File: gfs_supervisor.v */
// gfs_supervisor.v: menu simulation/restore, status indications and fault supervision
// assumes inputs synchronous to i_mclk; magnet inputs debounced; fault causes are levels
`timescale 1ns/1ps
`include "gfs_defines.vh"

// What this block does
// - full magnet hold past prompt plus 10 s starts simulation and its message.
// - simulation ramps loop 4 to 20 mA by 1% each second, then back.
// - the serial bus gas reading follows the same ramp while simulating.
// - simulation never times out; only the operator ends it.
// - 3 s hold ends simulation; down goes to prior item, up to next.
// - momentary hold moves menu item; 15 s without input returns to normal.
// - restore defaults needs a 10 s hold on the up input only.
// - restore sets ID 01, span 50, methane, factor 1.0; drops gain and cals.
// - over full scale: flash reading 100 and drive 22 mA while it lasts.
// - negative readings shown; below 10 ppm range an asterisk marks the sign.
// - during zero or span calibration, loop at 2.0 mA and status bit 14 set.
// - sensor life recomputed after each span calibration, shown and bus-readable.
// - count days since the last successful span calibration.
// - any fault scrolls a message every 30 s; swipe lists active faults.
// - most faults force 0 mA; temperature and span reminder do not.
// - each fault has its own register bit, held until its cause clears; zero, range, stability and clearing wait for a good calibration.
// - reading below -10% LEL gives zero fault until a good zero calibration.
// - failed signal-change check in span calibration latches range fault.
// - failed stability check latches stability fault; failed clearing check latches clearing fault; both until good span.
// - sensor signal out of limits gives sensor fault and 0 mA.
// - fault word: global 0x0001, span reminder 0x0002, temperature 0x0004.
// - 180 days since last span calibration raises span reminder, loop unchanged.
module gfs_supervisor #(
	parameter TICK_CYCLES = `GFS_TICK_CYCLES
) (
	input wire i_mclk,
	input wire i_rst_b,
	input wire i_magnet_input_down,
	input wire i_magnet_input_up,
	input wire i_menu_entered,
	input wire i_item_is_sim,
	input wire i_item_is_restore,
	input wire i_prompt_shown,
	input wire [7:0] i_loop_normal,
	input wire [15:0] i_gas_reading,
	input wire i_gas_negative,
	input wire [15:0] i_full_scale,
	input wire i_zero_cal_busy,
	input wire i_span_cal_busy,
	input wire i_zero_cal_ok,
	input wire i_span_cal_ok,
	input wire i_span_range_fail,
	input wire i_span_stab_fail,
	input wire i_span_clear_fail,
	input wire [6:0] i_span_life_calc,
	input wire i_sensor_limit_bad,
	input wire i_proc_err,
	input wire i_mem_err,
	input wire i_loop_err,
	input wire i_vin_err,
	input wire i_temp_err,
	output reg [7:0] o_loop_level,
	output reg [15:0] o_bus_reading,
	output reg o_sim_active_msg,
	output reg o_menu_prev,
	output reg o_menu_next,
	output reg o_menu_exit,
	output reg o_restoring_msg,
	output reg [7:0] o_serial_id,
	output reg [7:0] o_span_level,
	output reg [3:0] o_gas_type,
	output reg [7:0] o_gas_factor,
	output reg o_discard_cal,
	output reg o_flash_full_scale,
	output reg [15:0] o_disp_value,
	output reg o_disp_asterisk,
	output reg o_disp_minus,
	output reg [15:0] o_status_word,
	output reg [15:0] o_fault_word,
	output reg [10:0] o_fault_bits,
	output reg [6:0] o_sensor_life,
	output reg [15:0] o_days_since_span,
	output reg o_fault_msg,
	output reg [3:0] o_fault_list_idx,
	output reg o_fault_list_valid
);
	localparam ST_NORMAL = 4'b0001;
	localparam ST_MENU = 4'b0010;
	localparam ST_SIM = 4'b0100;
	localparam ST_RESTORE = 4'b1000;

	reg [3:0] state_reg;
	reg [3:0] state_next;
	wire tick;
	wire [5:0] dn_secs;
	wire [5:0] up_secs;
	wire dn_rel;
	wire up_rel;
	reg [4:0] idle_reg;
	reg [6:0] ramp_reg;
	reg ramp_down_reg;
	reg [16:0] sec_in_day_reg;
	reg [10:0] latch_reg;
	reg [4:0] msg_cnt_reg;
	reg [3:0] list_reg;
	reg listing_reg;
	reg restore_done_reg;
	// a long hold that caused a move must be let go before it counts again
	reg wait_rel_reg;
	reg [5:0] dn_last_reg;
	reg [5:0] up_last_reg;
	wire [10:0] cause;
	wire any_fault;
	wire loop_kill;

	gfs_sec_tick #(.TICK_CYCLES(TICK_CYCLES)) u_tick (
		.i_mclk(i_mclk),
		.i_rst_b(i_rst_b),
		.o_tick(tick)
	);

	gfs_hold_timer u_dn (
		.i_mclk(i_mclk),
		.i_rst_b(i_rst_b),
		.i_tick(tick),
		.i_held(i_magnet_input_down),
		.o_secs(dn_secs),
		.o_release(dn_rel)
	);

	gfs_hold_timer u_up (
		.i_mclk(i_mclk),
		.i_rst_b(i_rst_b),
		.i_tick(tick),
		.i_held(i_magnet_input_up),
		.o_secs(up_secs),
		.o_release(up_rel)
	);

	// scale a 0..100 ramp step onto 4..20 mA in 0.1 mA units: 40 + step*160/100
	function [7:0] ramp_to_loop;
		input [6:0] step;
		reg [15:0] prod;
		reg [15:0] sum;
		begin
			prod = {9'h0, step} * 16'h00a0;
			sum = `GFS_LOOP_MIN + prod / 16'h0064;
			ramp_to_loop = sum[7:0];
		end
	endfunction

	// sticky faults stay until their clearing event; live ones follow the cause
	assign cause[`GFS_F_ZERO] = i_gas_negative && (i_gas_reading > `GFS_NEG_LIMIT_LEL);
	assign cause[`GFS_F_RANGE] = i_span_range_fail;
	assign cause[`GFS_F_STAB] = i_span_stab_fail;
	assign cause[`GFS_F_CLEAR] = i_span_clear_fail;
	assign cause[`GFS_F_SENSOR] = i_sensor_limit_bad;
	assign cause[`GFS_F_PROC] = i_proc_err;
	assign cause[`GFS_F_MEM] = i_mem_err;
	assign cause[`GFS_F_LOOP] = i_loop_err;
	assign cause[`GFS_F_VIN] = i_vin_err;
	assign cause[`GFS_F_TEMP] = i_temp_err;
	assign cause[`GFS_F_SPANREM] = (o_days_since_span >= `GFS_SPAN_REMIND_DAYS);
	assign any_fault = |latch_reg;
	assign loop_kill = |latch_reg[`GFS_F_VIN:`GFS_F_ZERO];

	always @(posedge i_mclk) begin
		if (!i_rst_b) begin
			latch_reg <= 11'h0;
		end else begin
			// set wins over the clearing event in the same cycle
			latch_reg[`GFS_F_ZERO] <= cause[`GFS_F_ZERO] |
				(latch_reg[`GFS_F_ZERO] & ~i_zero_cal_ok);
			latch_reg[`GFS_F_RANGE] <= cause[`GFS_F_RANGE] |
				(latch_reg[`GFS_F_RANGE] & ~i_span_cal_ok);
			latch_reg[`GFS_F_STAB] <= cause[`GFS_F_STAB] |
				(latch_reg[`GFS_F_STAB] & ~i_span_cal_ok);
			latch_reg[`GFS_F_CLEAR] <= cause[`GFS_F_CLEAR] |
				(latch_reg[`GFS_F_CLEAR] & ~i_span_cal_ok);
			latch_reg[`GFS_F_SPANREM:`GFS_F_SENSOR] <=
				cause[`GFS_F_SPANREM:`GFS_F_SENSOR];
		end
	end

	always @* begin
		state_next = state_reg;
		case (state_reg)
			ST_NORMAL: begin
				if (i_menu_entered)
					state_next = ST_MENU;
			end
			ST_MENU: begin
				if (idle_reg >= `GFS_MENU_TIMEOUT_S)
					state_next = ST_NORMAL;
				else if (!wait_rel_reg && i_item_is_sim && i_prompt_shown &&
					(dn_secs >= `GFS_SIM_HOLD_S || up_secs >= `GFS_SIM_HOLD_S))
					state_next = ST_SIM;
				else if (!wait_rel_reg && i_item_is_restore && i_prompt_shown &&
					!i_magnet_input_down &&
					up_secs >= `GFS_RESTORE_HOLD_S)
					state_next = ST_RESTORE;
			end
			ST_SIM: begin
				// no idle timeout here on purpose
				if (!wait_rel_reg &&
					(dn_secs >= `GFS_STOP_HOLD_S || up_secs >= `GFS_STOP_HOLD_S))
					state_next = ST_MENU;
			end
			ST_RESTORE: begin
				if (restore_done_reg)
					state_next = ST_MENU;
			end
			default: state_next = ST_NORMAL;
		endcase
	end

	always @(posedge i_mclk) begin
		if (!i_rst_b) begin
			state_reg <= ST_NORMAL;
			idle_reg <= 5'h0;
			ramp_reg <= 7'h0;
			ramp_down_reg <= 1'b0;
			restore_done_reg <= 1'b0;
			wait_rel_reg <= 1'b0;
			dn_last_reg <= 6'h0;
			up_last_reg <= 6'h0;
			o_menu_prev <= 1'b0;
			o_menu_next <= 1'b0;
			o_menu_exit <= 1'b0;
			o_sim_active_msg <= 1'b0;
			o_restoring_msg <= 1'b0;
			o_discard_cal <= 1'b0;
			o_serial_id <= `GFS_DEF_SERIAL_ID;
			o_span_level <= `GFS_DEF_SPAN_LEVEL;
			o_gas_type <= `GFS_DEF_GAS_TYPE;
			o_gas_factor <= `GFS_DEF_GAS_FACTOR;
		end else begin
			state_reg <= state_next;
			o_menu_prev <= 1'b0;
			o_menu_next <= 1'b0;
			o_menu_exit <= 1'b0;
			o_discard_cal <= 1'b0;
			o_sim_active_msg <= (state_next == ST_SIM);
			o_restoring_msg <= (state_next == ST_RESTORE);
			restore_done_reg <= (state_reg == ST_RESTORE);
			dn_last_reg <= dn_secs;
			up_last_reg <= up_secs;
			if (!i_magnet_input_down && !i_magnet_input_up)
				wait_rel_reg <= 1'b0;
			else if (state_next != state_reg)
				wait_rel_reg <= 1'b1;
			if (state_reg != ST_MENU || i_magnet_input_down || i_magnet_input_up)
				idle_reg <= 5'h0;
			else if (tick && idle_reg != 5'h1f)
				idle_reg <= idle_reg + 5'h1;
			if (state_reg == ST_MENU && state_next == ST_NORMAL)
				o_menu_exit <= 1'b1;
			// a release before the 3 s stop-hold threshold is a momentary hold
			if (state_reg == ST_MENU && state_next == ST_MENU) begin
				o_menu_prev <= dn_rel && dn_last_reg < `GFS_STOP_HOLD_S;
				o_menu_next <= up_rel && up_last_reg < `GFS_STOP_HOLD_S;
			end
			if (state_reg == ST_SIM && state_next == ST_MENU) begin
				o_menu_prev <= dn_secs >= `GFS_STOP_HOLD_S;
				o_menu_next <= dn_secs < `GFS_STOP_HOLD_S;
			end
			if (state_reg != ST_SIM) begin
				ramp_reg <= 7'h0;
				ramp_down_reg <= 1'b0;
			end else if (tick) begin
				if (!ramp_down_reg) begin
					if (ramp_reg == `GFS_SIM_TOP - 7'h1)
						ramp_down_reg <= 1'b1;
					ramp_reg <= ramp_reg + 7'h1;
				end else begin
					if (ramp_reg == 7'h1)
						ramp_down_reg <= 1'b0;
					ramp_reg <= ramp_reg - 7'h1;
				end
			end
			if (state_reg == ST_MENU && state_next == ST_RESTORE) begin
				o_serial_id <= `GFS_DEF_SERIAL_ID;
				o_span_level <= `GFS_DEF_SPAN_LEVEL;
				o_gas_type <= `GFS_DEF_GAS_TYPE;
				o_gas_factor <= `GFS_DEF_GAS_FACTOR;
				o_discard_cal <= 1'b1;
			end
		end
	end

	// loop level priority: fault, calibration, simulation, over-range, normal
	always @(posedge i_mclk) begin
		if (!i_rst_b) begin
			o_loop_level <= `GFS_LOOP_MIN;
			o_bus_reading <= 16'h0;
			o_flash_full_scale <= 1'b0;
			o_disp_value <= 16'h0;
			o_disp_asterisk <= 1'b0;
			o_disp_minus <= 1'b0;
			o_status_word <= 16'h0;
			o_fault_word <= 16'h0;
			o_fault_bits <= 11'h0;
		end else begin
			if (loop_kill)
				o_loop_level <= `GFS_LOOP_FAULT;
			else if (i_zero_cal_busy || i_span_cal_busy)
				o_loop_level <= `GFS_LOOP_CAL;
			else if (state_reg == ST_SIM)
				o_loop_level <= ramp_to_loop(ramp_reg);
			else if (!i_gas_negative && i_gas_reading > i_full_scale)
				o_loop_level <= `GFS_LOOP_OVER;
			else
				o_loop_level <= i_loop_normal;
			if (state_reg == ST_SIM)
				o_bus_reading <= {9'h0, ramp_reg};
			else
				o_bus_reading <= i_gas_reading;
			o_flash_full_scale <= !i_gas_negative && i_gas_reading > i_full_scale;
			o_disp_value <= (!i_gas_negative && i_gas_reading > i_full_scale) ?
				`GFS_FULL_SCALE : i_gas_reading;
			o_disp_minus <= i_gas_negative;
			o_disp_asterisk <= i_gas_negative && (i_full_scale < `GFS_ASTERISK_RANGE);
			o_status_word <= {1'b0, i_zero_cal_busy | i_span_cal_busy,
				14'h0};
			o_fault_bits <= latch_reg;
			o_fault_word <= (any_fault ? `GFS_FSW_GLOBAL : 16'h0) |
				(latch_reg[`GFS_F_SPANREM] ? `GFS_FSW_SPAN_REM : 16'h0) |
				(latch_reg[`GFS_F_TEMP] ? `GFS_FSW_TEMP : 16'h0);
		end
	end

	// life figure and days counter; the day clock only runs from the tick
	always @(posedge i_mclk) begin
		if (!i_rst_b) begin
			o_sensor_life <= `GFS_SIM_TOP;
			o_days_since_span <= 16'h0;
			sec_in_day_reg <= 17'h0;
		end else begin
			if (i_span_cal_ok)
				o_sensor_life <= (i_span_life_calc > `GFS_SIM_TOP) ?
					`GFS_SIM_TOP : i_span_life_calc;
			if (i_span_cal_ok) begin
				o_days_since_span <= 16'h0;
				sec_in_day_reg <= 17'h0;
			end else if (tick) begin
				if (sec_in_day_reg == `GFS_SEC_PER_DAY - 1) begin
					sec_in_day_reg <= 17'h0;
					if (o_days_since_span != 16'hffff)
						o_days_since_span <= o_days_since_span + 16'h1;
				end else begin
					sec_in_day_reg <= sec_in_day_reg + 17'h1;
				end
			end
		end
	end

	// fault message every 30 s in normal operation; a swipe walks active faults
	always @(posedge i_mclk) begin
		if (!i_rst_b) begin
			msg_cnt_reg <= 5'h0;
			o_fault_msg <= 1'b0;
			list_reg <= 4'h0;
			listing_reg <= 1'b0;
			o_fault_list_idx <= 4'h0;
			o_fault_list_valid <= 1'b0;
		end else begin
			o_fault_msg <= 1'b0;
			o_fault_list_valid <= 1'b0;
			if (!any_fault || state_reg != ST_NORMAL) begin
				msg_cnt_reg <= 5'h0;
				listing_reg <= 1'b0;
			end else if (tick) begin
				if (msg_cnt_reg == `GFS_FAULT_MSG_S - 1) begin
					msg_cnt_reg <= 5'h0;
					o_fault_msg <= 1'b1;
				end else begin
					msg_cnt_reg <= msg_cnt_reg + 5'h1;
				end
			end
			if (o_fault_msg && (i_magnet_input_down || i_magnet_input_up)) begin
				listing_reg <= 1'b1;
				list_reg <= 4'h0;
			end else if (listing_reg && tick) begin
				if (latch_reg[list_reg]) begin
					o_fault_list_idx <= list_reg;
					o_fault_list_valid <= 1'b1;
				end
				if (list_reg == `GFS_NFAULT - 1)
					listing_reg <= 1'b0;
				else
					list_reg <= list_reg + 4'h1;
			end
		end
	end
endmodule

/* File: gfs_defines.vh */
// gfs_defines.vh: constants for the gas sensor fault supervisor
// assumes a 50 MHz device clock; all timing is built on a one-second tick
`ifndef GFS_DEFINES_VH
`define GFS_DEFINES_VH

`define GFS_CLK_HZ 50000000
`define GFS_TICK_CYCLES (`GFS_CLK_HZ)
`define GFS_SIM_HOLD_S 10
`define GFS_STOP_HOLD_S 3
`define GFS_RESTORE_HOLD_S 10
`define GFS_MENU_TIMEOUT_S 15
`define GFS_FAULT_MSG_S 30
`define GFS_SPAN_REMIND_DAYS 180
`define GFS_SEC_PER_DAY 86400

// loop levels in units of 0.1 mA
`define GFS_LOOP_FAULT 8'h00
`define GFS_LOOP_CAL 8'h14
`define GFS_LOOP_MIN 8'h28
`define GFS_LOOP_MAX 8'hc8
`define GFS_LOOP_OVER 8'hdc

// simulated reading in percent of range
`define GFS_SIM_TOP 7'h64
`define GFS_FULL_SCALE 16'h0064
`define GFS_NEG_LIMIT_LEL 16'h000a
`define GFS_ASTERISK_RANGE 16'h000a

// bus fault status word
`define GFS_FSW_GLOBAL 16'h0001
`define GFS_FSW_SPAN_REM 16'h0002
`define GFS_FSW_TEMP 16'h0004
`define GFS_STATUS_CAL_BIT 14

// diagnostic fault bit positions
`define GFS_F_ZERO 0
`define GFS_F_RANGE 1
`define GFS_F_STAB 2
`define GFS_F_CLEAR 3
`define GFS_F_SENSOR 4
`define GFS_F_PROC 5
`define GFS_F_MEM 6
`define GFS_F_LOOP 7
`define GFS_F_VIN 8
`define GFS_F_TEMP 9
`define GFS_F_SPANREM 10
`define GFS_NFAULT 11

// defaults restored
`define GFS_DEF_SERIAL_ID 8'h01
`define GFS_DEF_SPAN_LEVEL 8'h32
`define GFS_DEF_GAS_TYPE 4'h0
`define GFS_DEF_GAS_FACTOR 8'h0a

`endif

/* File: gfs_sec_tick.v */
// gfs_sec_tick.v: one-second tick divided down from the device clock
// assumes a synchronous active-low reset
`timescale 1ns/1ps
`include "gfs_defines.vh"

module gfs_sec_tick #(
	parameter TICK_CYCLES = `GFS_TICK_CYCLES
) (
	input wire i_mclk,
	input wire i_rst_b,
	output reg o_tick
);
	reg [25:0] cnt_reg;

	always @(posedge i_mclk) begin
		if (!i_rst_b) begin
			cnt_reg <= 26'h0;
			o_tick <= 1'b0;
		end else if (cnt_reg == TICK_CYCLES - 1) begin
			cnt_reg <= 26'h0;
			o_tick <= 1'b1;
		end else begin
			cnt_reg <= cnt_reg + 26'h1;
			o_tick <= 1'b0;
		end
	end
endmodule

/* File: gfs_hold_timer.v */
// gfs_hold_timer.v: counts whole seconds that a magnet input has been held
// assumes the magnet inputs are already debounced and synchronous
`timescale 1ns/1ps

module gfs_hold_timer (
	input wire i_mclk,
	input wire i_rst_b,
	input wire i_tick,
	input wire i_held,
	output reg [5:0] o_secs,
	output reg o_release
);
	reg held_d_reg;

	always @(posedge i_mclk) begin
		if (!i_rst_b) begin
			o_secs <= 6'h0;
			held_d_reg <= 1'b0;
			o_release <= 1'b0;
		end else begin
			held_d_reg <= i_held;
			o_release <= held_d_reg & ~i_held;
			if (!i_held)
				o_secs <= 6'h0;
			else if (i_tick && o_secs != 6'h3f)
				o_secs <= o_secs + 6'h1;
		end
	end
endmodule

/* File: gfs_operator.sv */
// gfs_operator.sv: operator model that holds one magnet for a set time
// assumes the supervisor samples the magnet levels on the rising clock edge
`timescale 1ns/1ps
module gfs_operator #(
	parameter TICK_CYCLES = 10
) (
	input wire i_mclk,
	input wire i_go,
	input wire i_up,
	input wire [7:0] i_tenths,
	output reg o_magnet_input_down = 1'b0,
	output reg o_magnet_input_up = 1'b0,
	output reg o_busy = 1'b0
);
	integer left = 0;
	// one unbroken hold per request; a lifted magnet reads plain low
	always @(posedge i_mclk) begin
		if (!o_busy && i_go) begin
			left <= i_tenths * TICK_CYCLES / 10;
			o_busy <= 1'b1;
			o_magnet_input_up <= i_up;
			o_magnet_input_down <= !i_up;
		end else if (o_busy && left > 1) begin
			left <= left - 1;
		end else begin
			o_busy <= 1'b0;
			o_magnet_input_up <= 1'b0;
			o_magnet_input_down <= 1'b0;
		end
	end
endmodule

/* File: gfs_supervisor_assertions.sv */
// gfs_supervisor_assertions.sv: port-level checks of the supervisor
// assumes one clock domain and a synchronous active-low reset
`timescale 1ns/1ps
module gfs_supervisor_chk (
	input logic i_mclk,
	input logic i_rst_b,
	input logic i_zero_cal_busy,
	input logic i_span_cal_busy,
	input logic i_span_cal_ok,
	input logic [7:0] o_loop_level,
	input logic [15:0] o_status_word,
	input logic [15:0] o_fault_word,
	input logic [10:0] o_fault_bits,
	input logic o_flash_full_scale,
	input logic [15:0] o_disp_value,
	input logic o_sim_active_msg,
	input logic o_menu_prev,
	input logic o_menu_next,
	input logic o_discard_cal,
	input logic [7:0] o_serial_id,
	input logic [7:0] o_span_level
);
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_rst_b);
	wire cal = i_zero_cal_busy | i_span_cal_busy;
	wire hard = |o_fault_bits[8:0];
	fault_loop_a: assert property ($rose(hard) |-> ##[0:2] o_loop_level == 8'h00)
		else $error("loop not at fault level");
	cal_level_a: assert property ($rose(cal) && !hard |-> ##[1:3]
		(o_loop_level == 8'h14 && o_status_word[14])) else $error("calibration level wrong");
	over_flash_a: assert property (o_flash_full_scale |-> o_disp_value == 16'h0064)
		else $error("flash without full scale value");
	temp_keeps_a: assert property ((o_fault_bits[9] && !hard && !cal)[*3]
		|-> o_loop_level != 8'h00) else $error("temperature fault dropped loop");
	word_global_a: assert property ((|o_fault_bits) |-> ##[0:1] o_fault_word[0])
		else $error("global fault bit missing");
	word_temp_a: assert property (o_fault_bits[9] |-> ##[0:1] o_fault_word[2])
		else $error("temperature word bit missing");
	sticky_range_a: assert property ($fell(o_fault_bits[1]) |->
		$past(i_span_cal_ok, 2) || $past(i_span_cal_ok, 3)) else $error("range fault cleared");
	sim_span_a: assert property (o_sim_active_msg && !hard && !cal |->
		o_loop_level >= 8'h28 && o_loop_level <= 8'hc8) else $error("ramp out of span");
	sim_stop_a: assert property ($fell(o_sim_active_msg) |-> ##[0:1]
		(o_menu_prev || o_menu_next)) else $error("simulation ended by itself");
	restore_def_a: assert property ($rose(o_discard_cal) |-> ##[0:2]
		(o_serial_id == 8'h01 && o_span_level == 8'h32)) else $error("defaults not set");
	cover property ($rose(o_sim_active_msg));
	cover property (o_discard_cal);
	cover property (o_flash_full_scale);
endmodule
bind gfs_supervisor gfs_supervisor_chk i_chk (.i_mclk, .i_rst_b, .i_zero_cal_busy,
	.i_span_cal_busy, .i_span_cal_ok, .o_loop_level, .o_status_word, .o_fault_word,
	.o_fault_bits, .o_flash_full_scale, .o_disp_value, .o_sim_active_msg, .o_menu_prev,
	.o_menu_next, .o_discard_cal, .o_serial_id, .o_span_level);

/* File: gfs_supervisor_tb.sv */
// gfs_supervisor_tb.sv: directed bench for the fault supervisor
// assumes TICK_CYCLES cut to 10, so one second is ten clocks
`timescale 1ns/1ps
module gfs_supervisor_tb;
	localparam TK = 10;
	logic i_mclk = 0, i_rst_b = 0, i_menu_entered = 0, i_item_is_sim = 0, i_item_is_restore = 0;
	logic i_prompt_shown = 1, i_gas_negative = 0, i_zero_cal_busy = 0, i_span_cal_busy = 0;
	logic i_zero_cal_ok = 0, i_span_cal_ok = 0, i_span_range_fail = 0, i_span_stab_fail = 0;
	logic i_span_clear_fail = 0, go = 0, up = 0, busy;
	logic [5:0] lv = 0;
	logic [7:0] i_loop_normal = 8'h50, tenths = 0;
	logic [15:0] i_gas_reading = 0, i_full_scale = 16'h0064;
	logic [6:0] i_span_life_calc = 0;
	wire i_sensor_limit_bad, i_proc_err, i_mem_err, i_loop_err, i_vin_err, i_temp_err;
	wire i_magnet_input_down, i_magnet_input_up;
	logic o_sim_active_msg, o_menu_prev, o_menu_next, o_menu_exit, o_restoring_msg;
	logic o_discard_cal, o_flash_full_scale, o_disp_asterisk, o_disp_minus, o_fault_msg;
	logic o_fault_list_valid;
	logic [7:0] o_loop_level, o_serial_id, o_span_level, o_gas_factor;
	logic [15:0] o_bus_reading, o_disp_value, o_status_word, o_fault_word, o_days_since_span;
	logic [10:0] o_fault_bits;
	logic [6:0] o_sensor_life;
	logic [3:0] o_gas_type, o_fault_list_idx;
	int n_errors = 0, checks = 0, cyc_n = 0, n_prev = 0, n_exit = 0, n_disc = 0;
	int n_rest = 0, n_msg = 0, n_list = 0;
	assign {i_temp_err, i_vin_err, i_loop_err, i_mem_err, i_proc_err, i_sensor_limit_bad} = lv;
	gfs_supervisor #(.TICK_CYCLES(TK)) i_gfs_supervisor (.*);
	gfs_operator #(.TICK_CYCLES(TK)) i_gfs_operator (.i_mclk(i_mclk), .i_go(go), .i_up(up),
		.i_tenths(tenths), .o_magnet_input_down(i_magnet_input_down),
		.o_magnet_input_up(i_magnet_input_up), .o_busy(busy));
	always #10 i_mclk = ~i_mclk;
	// pulses are counted here so a one-cycle strobe is never missed between checks
	always @(posedge i_mclk) begin
		cyc_n <= cyc_n + 1;
		n_prev <= n_prev + o_menu_prev;
		n_exit <= n_exit + o_menu_exit;
		n_disc <= n_disc + o_discard_cal;
		n_rest <= n_rest + o_restoring_msg;
		n_msg <= n_msg + o_fault_msg;
		n_list <= n_list + o_fault_list_valid;
		if (cyc_n == 6000) begin
			n_errors = n_errors + 1;
			give_verdict();
		end
	end
	task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("unexpected %s: expected %h, seen %h", nm, exp, got);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge i_mclk);
	endtask
	// holds one magnet for t tenths of a second, waiting for release under a bound
	task automatic hold(input logic u, input int t);
		go <= 1;
		up <= u;
		tenths <= t[7:0];
		cyc(1);
		go <= 0;
		cyc(2);
		for (int k = 0; k < 2000 && busy; k++) cyc(1);
	endtask
	task automatic give_verdict();
		$display("errors %0d, checks %0d", n_errors, checks);
		if (n_errors == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial begin
		cyc(19);
		#1;
		chk("reset loop", o_loop_level, 16'h28);
		chk("reset life", o_sensor_life, 16'h64);
		chk("reset days", o_days_since_span, 16'h0);
		cyc(1);
		i_rst_b <= 1;
		cyc(2);
		i_gas_reading <= 16'h0065;
		cyc(4); #1;
		chk("flash", o_flash_full_scale, 1);
		chk("over loop", o_loop_level, 16'h00dc);
		chk("over value", o_disp_value, 16'h0064);
		cyc(1); i_gas_reading <= 16'h0064; cyc(4); #1;
		chk("at scale", o_flash_full_scale, 0);
		cyc(1); i_gas_negative <= 1; i_gas_reading <= 16'h0006; cyc(4); #1;
		chk("minus", o_disp_minus, 1);
		chk("star wide", o_disp_asterisk, 0);
		cyc(1); i_full_scale <= 16'h0009; cyc(4); #1;
		chk("star", o_disp_asterisk, 1);
		cyc(1); i_full_scale <= 16'h000a; cyc(4); #1;
		chk("star at ten", o_disp_asterisk, 0);
		cyc(1); i_gas_reading <= 16'h000b; cyc(1); i_gas_reading <= 0; i_gas_negative <= 0;
		cyc(6); #1;
		chk("zero sticky", o_fault_bits, 16'h1);
		chk("zero loop", o_loop_level, 16'h0);
		cyc(1); i_zero_cal_ok <= 1; cyc(1); i_zero_cal_ok <= 0; cyc(4); #1;
		chk("zero cleared", o_fault_bits, 16'h0);
		cyc(1); {i_span_range_fail, i_span_stab_fail, i_span_clear_fail} <= 3'h7;
		cyc(1); {i_span_range_fail, i_span_stab_fail, i_span_clear_fail} <= 3'h0; cyc(6); #1;
		chk("span faults", o_fault_bits, 16'h000e);
		chk("span word", o_fault_word, 16'h0001);
		cyc(1); i_span_life_calc <= 7'h55; i_span_cal_ok <= 1;
		cyc(1); i_span_cal_ok <= 0; cyc(4); #1;
		chk("span cleared", o_fault_bits, 16'h0);
		chk("life", o_sensor_life, 16'h55);
		chk("days", o_days_since_span, 16'h0);
		for (int k = 0; k < 6; k++) begin
			cyc(1); lv <= 6'h1 << k; cyc(5); #1;
			chk("fault bit", o_fault_bits, 16'h10 << k);
			chk("fault loop", o_loop_level, k == 5 ? 16'h50 : 16'h0);
			chk("fault word", o_fault_word, k == 5 ? 16'h5 : 16'h1);
			cyc(1); lv <= 0; cyc(5); #1;
			chk("fault gone", o_fault_bits, 16'h0);
		end
		for (int k = 0; k < 2; k++) begin
			cyc(1); {i_span_cal_busy, i_zero_cal_busy} <= 2'h1 << k; cyc(4); #1;
			chk("cal loop", o_loop_level, 16'h14);
			chk("cal bit", o_status_word[14], 1);
			cyc(1); {i_span_cal_busy, i_zero_cal_busy} <= 2'h0;
		end
		cyc(3); lv <= 6'h20; cyc(100); hold(1, 250); cyc(120); #1;
		chk("fault message", n_msg > 0, 1);
		chk("fault listed", n_list > 0, 1);
		chk("listed index", o_fault_list_idx, 16'h9);
		cyc(1); lv <= 0; i_menu_entered <= 1; i_item_is_sim <= 1;
		cyc(1); i_menu_entered <= 0;
		hold(1, 85); #1;
		chk("short hold", o_sim_active_msg, 0);
		cyc(1); hold(1, 105); #1;
		chk("sim on", o_sim_active_msg, 1);
		cyc(400); #1;
		chk("ramp up", o_bus_reading inside {[35:45]}, 1);
		cyc(1000); #1;
		chk("ramp down", o_bus_reading inside {[50:70]}, 1);
		chk("no timeout", o_sim_active_msg, 1);
		cyc(1); hold(0, 35); cyc(2); #1;
		chk("sim stopped", o_sim_active_msg, 0);
		chk("prior item", n_prev, 1);
		cyc(130); #1;
		chk("menu kept", n_exit, 0);
		cyc(40); #1;
		chk("menu timeout", n_exit, 1);
		cyc(1); i_item_is_sim <= 0; i_item_is_restore <= 1; i_menu_entered <= 1;
		cyc(1); i_menu_entered <= 0;
		hold(0, 105); cyc(3); #1;
		chk("down refused", n_disc, 0);
		cyc(1); hold(1, 105); cyc(3); #1;
		chk("restore", n_disc, 1);
		chk("restoring msg", n_rest > 0, 1);
		chk("serial id", o_serial_id, 16'h01);
		chk("span level", o_span_level, 16'h32);
		chk("gas type", o_gas_type, 16'h0);
		chk("gas factor", o_gas_factor, 16'h0a);
		give_verdict();
	end
endmodule
